// File: hw/qba_defs.vh
// Purpose: Shared constants for the quad byte average unit
// Assumes: 8-bit byte address, 32-bit data port
// Notes: Offsets are byte addresses, one aligned word each
`ifndef QBA_DEFS_VH
`define QBA_DEFS_VH

// ==========================================================
// Register offsets
`define QBA_ADDR_W 8
`define QBA_OFS_DATA0 8'h00
`define QBA_OFS_DATA1 8'h04
`define QBA_OFS_DATA2 8'h08
`define QBA_OFS_DATA3 8'h0c
`define QBA_OFS_INDEX0 8'h10
`define QBA_OFS_INDEX1 8'h14
`define QBA_OFS_ARITH_STATUS 8'h18
`define QBA_OFS_COMMAND 8'h1c
`define QBA_OFS_RESULT 8'h20
`define QBA_OFS_STATUS 8'h24

// ==========================================================
// Command fields
`define QBA_CMD_HALFWORD 0
`define QBA_CMD_TRUNC 1
`define QBA_CMD_REVERSE 2
`define QBA_CMD_HIGH 3
`define QBA_CMD_PAIR0_LSB 4
`define QBA_CMD_PAIR1_LSB 6
`define QBA_CMD_W 8

// Pair codes; any other code names an unusable pair
`define QBA_PAIR_R10 2'h0
`define QBA_PAIR_R32 2'h1

// ==========================================================
// Status fields and reset values
`define QBA_STAT_DONE 0
`define QBA_STAT_BAD_PAIR 1
`define QBA_RND_MODE_BIT 0
`define QBA_RST_WORD 32'h0000_0000
`define QBA_RST_CMD 8'h00
`define QBA_ROUND_BYTE 9'h001
`define QBA_ROUND_HALF 10'h002

`endif

// File: hw/qba_align.v
// Purpose: Pick a 32-bit window from a 64-bit register pair
// Assumes: Purely combinational
// Notes: Reverse swaps the two words before the window is taken
`default_nettype none

// ==========================================================
// Aligner
module qba_align (
	// Pair words
	input wire [31:0] lo_i,
	input wire [31:0] hi_i,
	// Selection
	input wire [1:0] align_i,
	input wire reverse_i,
	// Window
	output reg [31:0] win_o
);
	reg [63:0] cat;

	always @* begin
		cat = reverse_i ? {lo_i, hi_i} : {hi_i, lo_i};
		if (!reverse_i) cat = {hi_i, lo_i};
		case (align_i)
			2'h0: win_o = cat[31:0];
			2'h1: win_o = cat[39:8];
			2'h2: win_o = cat[47:16];
			2'h3: win_o = cat[55:24];
			default: win_o = cat[31:0];
		endcase
	end
endmodule // qba_align

`default_nettype wire

// File: hw/qba_lanes.v
// Purpose: Byte and half-word averaging of two aligned words
// Assumes: Purely combinational, no state
// Notes: Rounding ignores any global rounding mode
`default_nettype none
`include "qba_defs.vh"

// ==========================================================
// Lane arithmetic
module qba_lanes (
	// Operands
	input wire [31:0] a_i,
	input wire [31:0] b_i,
	// Mode
	input wire halfword_i,
	input wire trunc_i,
	input wire high_i,
	// Result
	output reg [31:0] res_o
);
	// Unsigned widen keeps carries out of the lane
	function [7:0] avg2;
		input [7:0] x;
		input [7:0] y;
		input t;
		reg [8:0] s;
		begin
			s = {1'b0, x} + {1'b0, y} + (t ? 9'h000 : `QBA_ROUND_BYTE);
			avg2 = s[8:1];
		end
	endfunction

	function [7:0] avg4;
		input [15:0] x;
		input [15:0] y;
		input t;
		reg [9:0] s;
		begin
			s = {2'h0, x[7:0]} + {2'h0, x[15:8]} + {2'h0, y[7:0]} + {2'h0, y[15:8]}
				+ (t ? 10'h000 : `QBA_ROUND_HALF);
			avg4 = s[9:2];
		end
	endfunction

	reg [7:0] h0;
	reg [7:0] h1;

	always @* begin
		h0 = avg4(a_i[15:0], b_i[15:0], trunc_i);
		h1 = avg4(a_i[31:16], b_i[31:16], trunc_i);
		if (halfword_i) begin
			res_o = high_i ? {h1, 8'h00, h0, 8'h00} : {8'h00, h1, 8'h00, h0};
		end else begin
			res_o = {avg2(a_i[31:24], b_i[31:24], trunc_i), avg2(a_i[23:16], b_i[23:16], trunc_i),
				avg2(a_i[15:8], b_i[15:8], trunc_i), avg2(a_i[7:0], b_i[7:0], trunc_i)};
		end
	end
endmodule // qba_lanes

`default_nettype wire

// File: hw/qba_top.v
// Purpose: Quad byte average unit with its operand registers
// Assumes: Single clock, synchronous active-high reset
// Notes: Writing the command word issues one operation
//
// Chosen here: the address map and the plain strobed port.
`default_nettype none
`include "qba_defs.vh"

// ==========================================================
// Top level
module qba_top (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Register port
	input wire [`QBA_ADDR_W-1:0] addr_i,
	input wire [31:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [31:0] rdata_o,
	// Operation results
	output reg [31:0] result_o,
	output reg done_o,
	output reg bad_pair_o
);

	// ==========================================================
	// Software state
	reg [31:0] data0_q;
	reg [31:0] data1_q;
	reg [31:0] data2_q;
	reg [31:0] data3_q;
	reg [1:0] index0_q;
	reg [1:0] index1_q;
	reg rnd_mode_q;
	reg [`QBA_CMD_W-1:0] cmd_q;
	reg go_q;
	reg done_stat_q;

	wire wr_cmd;
	assign wr_cmd = wr_i && (addr_i == `QBA_OFS_COMMAND);

	// ==========================================================
	// Pair fetch
	// Returns {hi, lo}; unusable codes return zero
	function [63:0] fetch_pair;
		input [1:0] code;
		input [31:0] r0;
		input [31:0] r1;
		input [31:0] r2;
		input [31:0] r3;
		begin
			case (code)
				`QBA_PAIR_R10: fetch_pair = {r1, r0};
				`QBA_PAIR_R32: fetch_pair = {r3, r2};
				default: fetch_pair = 64'h0000_0000_0000_0000;
			endcase
		end
	endfunction

	function pair_ok;
		input [1:0] code;
		begin
			pair_ok = (code == `QBA_PAIR_R10) || (code == `QBA_PAIR_R32);
		end
	endfunction

	// ==========================================================
	// Command decode
	wire op_half;
	wire op_trunc;
	wire op_rev;
	wire op_high;
	wire [1:0] pair0_code;
	wire [1:0] pair1_code;
	wire pairs_ok;

	assign op_half = cmd_q[`QBA_CMD_HALFWORD];
	assign op_trunc = cmd_q[`QBA_CMD_TRUNC];
	assign op_rev = cmd_q[`QBA_CMD_REVERSE];
	assign op_high = cmd_q[`QBA_CMD_HIGH];
	assign pair0_code = cmd_q[`QBA_CMD_PAIR0_LSB+1:`QBA_CMD_PAIR0_LSB];
	assign pair1_code = cmd_q[`QBA_CMD_PAIR1_LSB+1:`QBA_CMD_PAIR1_LSB];
	assign pairs_ok = pair_ok(pair0_code) && pair_ok(pair1_code);

	// ==========================================================
	// Operand selection
	wire [63:0] pair0;
	wire [63:0] pair1;
	wire [1:0] align1;

	assign pair0 = fetch_pair(pair0_code, data0_q, data1_q, data2_q, data3_q);
	assign pair1 = fetch_pair(pair1_code, data0_q, data1_q, data2_q, data3_q);
	// Half-word form has a single alignment source
	assign align1 = op_half ? index0_q : index1_q;

	wire [31:0] win0;
	wire [31:0] win1;
	wire [31:0] avg_res;

	// Alignment from the pair itself, so loads stay word aligned
	qba_align u_align0 (
		.lo_i(pair0[31:0]),
		.hi_i(pair0[63:32]),
		.align_i(index0_q),
		.reverse_i(op_rev),
		.win_o(win0)
	);

	qba_align u_align1 (
		.lo_i(pair1[31:0]),
		.hi_i(pair1[63:32]),
		.align_i(align1),
		.reverse_i(op_rev),
		.win_o(win1)
	);

	// No global rounding mode reaches the lanes
	qba_lanes u_lanes (
		.a_i(win0),
		.b_i(win1),
		.halfword_i(op_half),
		.trunc_i(op_trunc),
		.high_i(op_high),
		.res_o(avg_res)
	);

	// ==========================================================
	// Register writes
	always @(posedge clk_i) begin
		if (rst_i) begin
			data0_q <= `QBA_RST_WORD;
			data1_q <= `QBA_RST_WORD;
			data2_q <= `QBA_RST_WORD;
			data3_q <= `QBA_RST_WORD;
			index0_q <= 2'h0;
			index1_q <= 2'h0;
			rnd_mode_q <= 1'b0;
			cmd_q <= `QBA_RST_CMD;
		end else if (wr_i) begin
			case (addr_i)
				`QBA_OFS_DATA0: data0_q <= wdata_i;
				`QBA_OFS_DATA1: data1_q <= wdata_i;
				`QBA_OFS_DATA2: data2_q <= wdata_i;
				`QBA_OFS_DATA3: data3_q <= wdata_i;
				`QBA_OFS_INDEX0: index0_q <= wdata_i[1:0];
				`QBA_OFS_INDEX1: index1_q <= wdata_i[1:0];
				// Stored for software only
				`QBA_OFS_ARITH_STATUS: rnd_mode_q <= wdata_i[`QBA_RND_MODE_BIT];
				`QBA_OFS_COMMAND: cmd_q <= wdata_i[`QBA_CMD_W-1:0];
				default: cmd_q <= cmd_q;
			endcase
		end
	end

	// ==========================================================
	// Issue and completion
	// One command per cycle accepted, never a busy wait
	always @(posedge clk_i) begin
		if (rst_i) begin
			go_q <= 1'b0;
		end else begin
			go_q <= wr_cmd;
		end
	end

	// A completion in the same cycle as a new command write wins the done flag
	always @(posedge clk_i) begin
		if (rst_i) begin
			result_o <= `QBA_RST_WORD;
			done_o <= 1'b0;
			done_stat_q <= 1'b0;
			bad_pair_o <= 1'b0;
		end else begin
			done_o <= go_q;
			if (go_q) begin
				done_stat_q <= 1'b1;
				bad_pair_o <= ~pairs_ok;
				// A bad pair leaves the previous result in place
				if (pairs_ok) begin
					result_o <= avg_res;
				end
			end else if (wr_cmd) begin
				done_stat_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read port
	reg [31:0] rd_mux;

	always @* begin
		case (addr_i)
			`QBA_OFS_DATA0: rd_mux = data0_q;
			`QBA_OFS_DATA1: rd_mux = data1_q;
			`QBA_OFS_DATA2: rd_mux = data2_q;
			`QBA_OFS_DATA3: rd_mux = data3_q;
			`QBA_OFS_INDEX0: rd_mux = {30'h0, index0_q};
			`QBA_OFS_INDEX1: rd_mux = {30'h0, index1_q};
			`QBA_OFS_ARITH_STATUS: rd_mux = {31'h0, rnd_mode_q};
			`QBA_OFS_COMMAND: rd_mux = {24'h0, cmd_q};
			`QBA_OFS_RESULT: rd_mux = result_o;
			`QBA_OFS_STATUS: rd_mux = {30'h0, bad_pair_o, done_stat_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Data valid only in the cycle after the strobe
	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= `QBA_RST_WORD;
		end else if (rd_i) begin
			rdata_o <= rd_mux;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

endmodule // qba_top

`default_nettype wire

// File: dv/qba_monitor.sv
// Purpose: Port checks for qba_top
// Assumes: One clock, sync reset high
// Notes: Bound to every qba_top
`default_nettype none
// ====
// Checker
module qba_monitor (
	// Watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [31:0] result_o,
	input wire logic done_o,
	input wire logic bad_pair_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire cmd = wr_i && addr_i == 8'h1c;
	chk_done_lat: assert property (cmd |-> ##2 done_o) else $error("done late");
	chk_done_src: assert property (done_o |-> $past(cmd, 2)) else $error("stray done");
	chk_b2b_issue: assert property (cmd ##1 cmd |-> ##1 done_o [*2]) else $error("issue stalled");
	chk_bad_code: assert property (done_o |-> bad_pair_o == ($past(wdata_i[5], 2) | $past(wdata_i[7], 2)))
		else $error("bad pair flag wrong");
	chk_bad_keep: assert property (done_o && bad_pair_o && !$past(rst_i) |-> $stable(result_o))
		else $error("bad pair changed result");
	chk_res_hold: assert property (!done_o && !$past(rst_i) |-> $stable(result_o))
		else $error("result moved idle");
	chk_bad_hold: assert property (!done_o && !$past(rst_i) |-> $stable(bad_pair_o))
		else $error("flag moved idle");
	chk_hw_zero: assert property (done_o && !bad_pair_o && $past(wdata_i[0], 2) |->
		(result_o & ($past(wdata_i[3], 2) ? 32'h00ff00ff : 32'hff00ff00)) == 32'h0) else $error("fill not zero");
	cov_hw: cover property (done_o && !bad_pair_o && $past(wdata_i[0], 2));
	cov_bad: cover property (done_o && bad_pair_o);
	cov_b2b: cover property (done_o [*2]);
endmodule // qba_monitor
bind qba_top qba_monitor u_mon (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .result_o, .done_o,
	.bad_pair_o);
`default_nettype wire

// File: dv/qba_host_model.sv
// Purpose: Host side that drives the register port
// Assumes: Called right after a rising edge
// Notes: The write strobe stays up between calls; idle drops it, get drops its own read strobe
`default_nettype none
// ====
// Host
module qba_host_model (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [31:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		addr_o = 8'h00;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		rd_o <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic idle;
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic get(input logic [7:0] a, output logic [31:0] d);
		addr_o <= a;
		wr_o <= 1'b0;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask
endmodule // qba_host_model
`default_nettype wire

// File: dv/qba_top_tb.sv
// Purpose: Self-checking bench for qba_top
// Assumes: Host model drives the register port
// Notes: Sweeps all command bytes and alignments
`default_nettype none
// ====
// Bench
module qba_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o, result_o, got, exp_q;
	logic wr_i, rd_i, done_o, bad_pair_o, bad_e;
	logic [31:0] r [4];
	int err_total = 0;
	int checked = 0;
	always #20 clk_i = ~clk_i;
	qba_host_model host (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
	qba_top dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .result_o, .done_o, .bad_pair_o);
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic stop_test;
		if (err_total == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Reference kept apart from the design's own arithmetic
	function automatic logic [31:0] model(logic [7:0] c, logic [1:0] a0, logic [1:0] a1);
		logic [63:0] p, q;
		logic [31:0] x, y, o;
		logic [9:0] s;
		p = c[2] ? {r[2*c[4]], r[2*c[4]+1]} : {r[2*c[4]+1], r[2*c[4]]};
		q = c[2] ? {r[2*c[6]], r[2*c[6]+1]} : {r[2*c[6]+1], r[2*c[6]]};
		x = p >> (8 * a0);
		y = q >> (8 * (c[0] ? a0 : a1));
		for (int k = 0; k < 4; k++) begin
			s = x[8*k+:8] + y[8*k+:8] + !c[1];
			o[8*k+:8] = s[8:1];
		end
		for (int k = 0; k < 2 && c[0]; k++) begin
			s = x[16*k+:8] + x[16*k+8+:8] + y[16*k+:8] + y[16*k+8+:8] + (c[1] ? 10'h0 : 10'h2);
			o[16*k+:16] = c[3] ? {s[9:2], 8'h00} : {8'h00, s[9:2]};
		end
		return o;
	endfunction
	initial begin
		repeat (50000) @(posedge clk_i);
		err_total++;
		stop_test;
	end
	initial begin
		logic [7:0] c;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, unmapped 0x28 reads zero
		for (int a = 0; a <= 40; a += 4) begin
			host.get(a[7:0], got);
			chk("reset", 32'h0, got);
		end
		host.put(8'h20, 32'hffffffff);
		host.get(8'h20, got);
		chk("ro", 32'h0, got);
		exp_q = 32'h0;
		for (int n = 0; n < 4096; n++) begin
			c = n[11:4];
			for (int k = 0; k < 4 && n[3:0] == 4'h0; k++) begin
				r[k] = 32'h9e3779b9 * (n + k + 1);
				host.put(8'(4 * k), r[k]);
			end
			host.put(8'h10, {30'h0, n[1:0]});
			host.put(8'h14, {30'h0, n[3:2]});
			host.put(8'h18, {31'h0, n[0]});
			host.put(8'h1c, {24'h0, c});
			host.idle;
			for (int w = 0; w < 4 && done_o !== 1'b1; w++) @(posedge clk_i);
			chk("done", 32'h1, {31'h0, done_o});
			bad_e = c[5] | c[7];
			if (!bad_e) exp_q = model(c, n[1:0], n[3:2]);
			chk("result", exp_q, result_o);
			chk("bad", {31'h0, bad_e}, {31'h0, bad_pair_o});
			host.get(8'h24, got);
			chk("status", {30'h0, bad_e, 1'b1}, got);
		end
		// Back to back commands, one cycle each
		host.put(8'h1c, 8'h00);
		host.put(8'h1c, 8'h01);
		host.idle;
		repeat (2) @(posedge clk_i);
		chk("b2b", model(8'h01, 2'h3, 2'h3), result_o);
		// Read back what software wrote last
		host.get(8'h0c, got);
		chk("data3", r[3], got);
		host.get(8'h14, got);
		chk("index1", 32'h3, got);
		host.get(8'h18, got);
		chk("arith", 32'h1, got);
		host.get(8'h1c, got);
		chk("cmd", 32'h1, got);
		// Reset in mid-run clears results and operands
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("rst result", 32'h0, result_o);
		chk("rst bad", 32'h0, {31'h0, bad_pair_o});
		host.get(8'h00, got);
		chk("rst data0", 32'h0, got);
		host.get(8'h24, got);
		chk("rst status", 32'h0, got);
		stop_test;
	end
endmodule // qba_top_tb
`default_nettype wire
